// ==== inc/lpc_defs.svh ====
// Purpose: Offsets, field positions, reset values and fixed-point constants of the position compensator.
// Assumes: Registers are 32-bit words on a plain strobe port; positions are in units of 1/256 nm.
// Notes:   Included by its bare name; definitions only.
`ifndef LPC_DEFS_SVH
`define LPC_DEFS_SVH

// Register byte offsets.
`define LPC_OFS_CTRL       8'h00
`define LPC_OFS_LAM_NTP    8'h04
`define LPC_OFS_LAM_CUR    8'h08
`define LPC_OFS_DEAD_PATH  8'h0C
`define LPC_OFS_ST_COEF    8'h10
`define LPC_OFS_ST_TEMP    8'h14
`define LPC_OFS_WP_COEF    8'h18
`define LPC_OFS_WP_TEMP    8'h1C
`define LPC_OFS_WP_OFFSET  8'h20
`define LPC_OFS_COUNT      8'h24
`define LPC_OFS_LAM_REF    8'h28
`define LPC_OFS_AXIS_LO    8'h2C
`define LPC_OFS_AXIS_HI    8'h30
`define LPC_OFS_OUT_LO     8'h34
`define LPC_OFS_OUT_HI     8'h38
`define LPC_OFS_STATUS     8'h3C

// Control register fields.
`define LPC_CTRL_WPC_EN    0
`define LPC_CTRL_DPASS     1
`define LPC_CTRL_INTERP_LO 2
`define LPC_CTRL_INTERP_HI 5

// Reset values.
`define LPC_RST_CTRL       32'h0000_0000
`define LPC_RST_LAM        32'h0000_0000
`define LPC_RST_WORD       32'h0000_0000

// Widths and fixed-point scaling.
`define LPC_POS_W          48
`define LPC_LAM_FRAC       22
`define LPC_POS_FRAC       8
`define LPC_RATIO_FRAC     32
`define LPC_T20_Q16        33'sh0_0014_0000
`define LPC_UM_TO_POS      56'sd256000
`define LPC_PPM_Q40        136'sd1099512
`define LPC_DIV_W          64

`endif

// ==== inc/lpc_pkg.sv ====
// Purpose: Types shared by the position compensator files.
// Assumes: Widths come from lpc_defs.svh.
// Notes:   Nothing is imported; users write lpc_pkg::name.
`include "lpc_defs.svh"

package lpc_pkg;

  // Sequencer states, one-hot.
  typedef enum logic [5:0]
  {
    ST_DIV  = 6'b000001,
    ST_MUL  = 6'b000010,
    ST_AXIS = 6'b000100,
    ST_WP1  = 6'b001000,
    ST_WP2  = 6'b010000,
    ST_OUT  = 6'b100000
  } lpc_state_e;

  // Register port request.
  typedef struct packed
  {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } lpc_bus_s;

  // Result handed to the servo-controller.
  typedef struct packed
  {
    logic                         valid;
    logic signed [`LPC_POS_W-1:0] axis;
    logic signed [`LPC_POS_W-1:0] pos;
  } lpc_out_s;

endpackage

// ==== hdl/lpc_div.sv ====
// Purpose: Sequential signed-by-unsigned divider for the wavelength ratios.
// Assumes: Denominator is a positive wavelength; zero gives a zero quotient.
// Notes:   One quotient bit per cycle, NW cycles from start to done.
`timescale 1ns/1ps

module lpc_div #(
  parameter int NW = 64,
  parameter int DW = 32
) (
  // Clock and reset.
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  // Operands.
  input  wire logic                 start_i,
  input  wire logic signed [NW-1:0] num_i,
  input  wire logic        [DW-1:0] den_i,
  // Result.
  output logic                      done_o,
  output logic signed [NW-1:0]      quo_o
);

  logic [NW-1:0] q_ff;
  logic [DW:0]   rem_ff;
  logic [DW-1:0] den_ff;
  logic          neg_ff;
  logic [7:0]    cnt_ff;
  logic          busy_ff;

  // One restoring step: shift in the next dividend bit and subtract when it fits.
  wire  [DW:0]   rem_sh  = {rem_ff[DW-1:0], q_ff[NW-1]};
  wire           fits    = rem_sh >= {1'b0, den_ff};
  wire  [DW:0]   nxt_rem = fits ? rem_sh - {1'b0, den_ff} : rem_sh;
  wire  [NW-1:0] nxt_q   = {q_ff[NW-2:0], fits};
  wire  [NW-1:0] mag_num = num_i[NW-1] ? -num_i : num_i;
  wire           last    = busy_ff && (cnt_ff == 8'h01);

  // The sign is reapplied at the end so the magnitude loop stays unsigned.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      q_ff    <= '0;
      rem_ff  <= '0;
      den_ff  <= '0;
      neg_ff  <= 1'b0;
      cnt_ff  <= 8'h00;
      busy_ff <= 1'b0;
      done_o  <= 1'b0;
      quo_o   <= '0;
    end
    else
    begin
      done_o <= last;
      if (start_i && !busy_ff)
      begin
        q_ff    <= mag_num;
        rem_ff  <= '0;
        den_ff  <= den_i;
        neg_ff  <= num_i[NW-1];
        cnt_ff  <= 8'(NW);
        busy_ff <= 1'b1;
      end
      else if (busy_ff)
      begin
        q_ff    <= nxt_q;
        rem_ff  <= nxt_rem;
        cnt_ff  <= cnt_ff - 8'h01;
        busy_ff <= !last;
        if (last)
        begin
          quo_o <= (den_ff == '0) ? '0 : (neg_ff ? -$signed(nxt_q) : $signed(nxt_q));
        end
      end
    end
  end

endmodule

// ==== hdl/lpc_top.sv ====
// Purpose: Turns an interferometer quadrature count into a compensated axis position.
// Assumes: Quadrature and reference pins are asynchronous; registers are written by software.
// Notes:   Positions use 1/256 nm units, wavelengths nm in Q22, temperatures and coefficients Q16.
`timescale 1ns/1ps
`include "lpc_defs.svh"

module lpc_top #(
  parameter int POS_W = `LPC_POS_W
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Laser encoder pins.
  input  wire logic             quad_a_i,
  input  wire logic             quad_b_i,
  input  wire logic             ref_i,
  // Register port.
  input  wire lpc_pkg::lpc_bus_s bus_i,
  output logic [31:0]           rdata_o,
  // Servo-controller side.
  output lpc_pkg::lpc_out_s     out_o
);

  // Pin synchronisers and edge history.
  logic [2:0] a_sync_ff;
  logic [2:0] b_sync_ff;
  logic [2:0] r_sync_ff;

  // Software registers.
  logic [31:0] ctrl_ff;
  logic [31:0] lam_ntp_ff;
  logic [31:0] lam_cur_ff;
  logic [31:0] dead_ff;
  logic [31:0] st_coef_ff;
  logic [31:0] st_temp_ff;
  logic [31:0] wp_coef_ff;
  logic [31:0] wp_temp_ff;
  logic [31:0] wp_off_ff;

  // Captured state.
  logic signed [31:0]      cnt_ff;
  logic [31:0]             lam_ref_ff;
  logic                    refd_ff;
  logic                    wpc_on_ff;
  logic signed [POS_W-1:0] wce_ff;

  // Pipeline registers.
  lpc_pkg::lpc_state_e     state_ff;
  logic signed [POS_W-1:0] pos_in_ff;
  logic signed [POS_W-1:0] wl_corr_ff;
  logic signed [POS_W-1:0] dp_corr_ff;
  logic signed [POS_W-1:0] st_corr_ff;
  logic signed [POS_W-1:0] axis_ff;
  logic signed [71:0]      wp1_ff;
  logic signed [POS_W-1:0] wp_corr_ff;
  logic                    div_start_ff;

  // Divider results.
  logic                           r1_done;
  logic                           r2_done;
  logic signed [`LPC_DIV_W-1:0]   r1;
  logic signed [`LPC_DIV_W-1:0]   r2;

  // Quadrature step code: 01 forward, 11 reverse, 00 none or illegal jump.
  function automatic logic [1:0] quad_step(input logic [1:0] prv, input logic [1:0] cur);
    logic [1:0] res;
    res = 2'h0;
    unique case ({prv, cur})
      4'h1, 4'h7, 4'hE, 4'h8: res = 2'h1;
      4'h2, 4'hB, 4'hD, 4'h4: res = 2'h3;
      default:                res = 2'h0;
    endcase
    return res;
  endfunction

  // Decoded pin events, read only from the second and third stages.
  wire [1:0] step    = quad_step({a_sync_ff[2], b_sync_ff[2]}, {a_sync_ff[1], b_sync_ff[1]});
  wire       ref_evt = r_sync_ff[1] & ~r_sync_ff[2];
  wire       wpc_en  = ctrl_ff[`LPC_CTRL_WPC_EN];
  wire       wpc_rise = wpc_en & ~wpc_on_ff;

  // Nominal resolution: each interpolation halving and a double pass both divide the wavelength.
  wire [4:0]  res_sh = 5'(ctrl_ff[`LPC_CTRL_INTERP_HI:`LPC_CTRL_INTERP_LO]) + 5'(ctrl_ff[`LPC_CTRL_DPASS]);
  wire [31:0] res_q22 = lam_ntp_ff >> res_sh;

  // Input position: count times resolution, Q22 nm brought down to 1/256 nm.
  wire signed [79:0] pin_full = 80'(cnt_ff) * $signed({48'h0, res_q22});
  wire signed [POS_W-1:0] pos_in = pin_full[`LPC_LAM_FRAC-`LPC_POS_FRAC +: POS_W];

  // Ratio numerators: wavelength difference in Q32 of the divisor; the small difference keeps this safe.
  wire signed [32:0] d_ntp = $signed({1'b0, lam_cur_ff}) - $signed({1'b0, lam_ntp_ff});
  wire signed [32:0] d_ref = $signed({1'b0, lam_cur_ff}) - $signed({1'b0, lam_ref_ff});
  wire signed [`LPC_DIV_W-1:0] num1 = {d_ntp[31:0], 32'h0};
  wire signed [`LPC_DIV_W-1:0] num2 = {d_ref[31:0], 32'h0};

  // Correction products, each brought back to position units.
  wire signed [55:0]  dead_s  = 56'($signed(dead_ff));
  wire signed [55:0]  dp_pos  = dead_s * `LPC_UM_TO_POS;
  wire signed [111:0] wl_full = 112'(pos_in_ff) * 112'(r1);
  wire signed [111:0] dp_full = 112'(dp_pos) * 112'(r2);
  wire signed [32:0]  st_dt   = `LPC_T20_Q16 - $signed({st_temp_ff[31], st_temp_ff});
  wire signed [95:0]  st_full = 96'($signed(st_coef_ff)) * 96'(st_dt) * 96'(`LPC_UM_TO_POS);

  // Workpiece correction in two stages to keep each multiplier chain short.
  wire signed [55:0]  wo_pos  = 56'($signed(wp_off_ff)) * `LPC_UM_TO_POS;
  wire signed [55:0]  dpos    = 56'(axis_ff) - 56'(wce_ff) - wo_pos;
  wire signed [87:0]  wp1     = 88'(dpos) * 88'($signed(wp_coef_ff));
  wire signed [32:0]  wp_dt   = `LPC_T20_Q16 - $signed({wp_temp_ff[31], wp_temp_ff});
  wire signed [135:0] wp2     = 136'(wp1_ff) * 136'(wp_dt) * `LPC_PPM_Q40;

  // Sum of the axis corrections; a positive correction raises the reported position.
  wire signed [POS_W-1:0] axis_sum = pos_in_ff + wl_corr_ff + dp_corr_ff + st_corr_ff;
  wire signed [POS_W-1:0] out_sum  = axis_ff + wp_corr_ff;

  // Register read selection.
  wire [31:0] rd_mux =
      (bus_i.addr == `LPC_OFS_CTRL)      ? ctrl_ff :
      (bus_i.addr == `LPC_OFS_LAM_NTP)   ? lam_ntp_ff :
      (bus_i.addr == `LPC_OFS_LAM_CUR)   ? lam_cur_ff :
      (bus_i.addr == `LPC_OFS_DEAD_PATH) ? dead_ff :
      (bus_i.addr == `LPC_OFS_ST_COEF)   ? st_coef_ff :
      (bus_i.addr == `LPC_OFS_ST_TEMP)   ? st_temp_ff :
      (bus_i.addr == `LPC_OFS_WP_COEF)   ? wp_coef_ff :
      (bus_i.addr == `LPC_OFS_WP_TEMP)   ? wp_temp_ff :
      (bus_i.addr == `LPC_OFS_WP_OFFSET) ? wp_off_ff :
      (bus_i.addr == `LPC_OFS_COUNT)     ? cnt_ff :
      (bus_i.addr == `LPC_OFS_LAM_REF)   ? lam_ref_ff :
      (bus_i.addr == `LPC_OFS_AXIS_LO)   ? out_o.axis[31:0] :
      (bus_i.addr == `LPC_OFS_AXIS_HI)   ? 32'(out_o.axis[POS_W-1:32]) :
      (bus_i.addr == `LPC_OFS_OUT_LO)    ? out_o.pos[31:0] :
      (bus_i.addr == `LPC_OFS_OUT_HI)    ? 32'(out_o.pos[POS_W-1:32]) :
      (bus_i.addr == `LPC_OFS_STATUS)    ? {30'h0, wpc_on_ff, refd_ff} :
                                           32'h0000_0000;

  // Two dividers run side by side so both ratios take the same time.
  lpc_div #(
    .NW (`LPC_DIV_W),
    .DW (32)
  ) u_div_ntp (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .start_i (div_start_ff),
    .num_i   (num1),
    .den_i   (lam_ntp_ff),
    .done_o  (r1_done),
    .quo_o   (r1)
  );

  lpc_div #(
    .NW (`LPC_DIV_W),
    .DW (32)
  ) u_div_ref (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .start_i (div_start_ff),
    .num_i   (num2),
    .den_i   (lam_ref_ff),
    .done_o  (r2_done),
    .quo_o   (r2)
  );

  // Pin synchronisers; only the second and third stages are decoded.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      a_sync_ff <= 3'h0;
      b_sync_ff <= 3'h0;
      r_sync_ff <= 3'h0;
    end
    else
    begin
      a_sync_ff <= {a_sync_ff[1:0], quad_a_i};
      b_sync_ff <= {b_sync_ff[1:0], quad_b_i};
      r_sync_ff <= {r_sync_ff[1:0], ref_i};
    end
  end

  // Referenced counter and reference-time wavelength; the reference wins over a step.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt_ff     <= 32'sh0;
      lam_ref_ff <= `LPC_RST_LAM;
      refd_ff    <= 1'b0;
    end
    else if (ref_evt)
    begin
      cnt_ff     <= 32'sh0;
      lam_ref_ff <= lam_cur_ff;
      refd_ff    <= 1'b1;
    end
    else if (step != 2'h0)
    begin
      cnt_ff <= cnt_ff + ((step == 2'h1) ? 32'sh1 : -32'sh1);
    end
  end

  // Software writes; a write to a read-only offset is ignored.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_ff    <= `LPC_RST_CTRL;
      lam_ntp_ff <= `LPC_RST_LAM;
      lam_cur_ff <= `LPC_RST_LAM;
      dead_ff    <= `LPC_RST_WORD;
      st_coef_ff <= `LPC_RST_WORD;
      st_temp_ff <= `LPC_RST_WORD;
      wp_coef_ff <= `LPC_RST_WORD;
      wp_temp_ff <= `LPC_RST_WORD;
      wp_off_ff  <= `LPC_RST_WORD;
    end
    else if (bus_i.wr)
    begin
      unique case (bus_i.addr)
        `LPC_OFS_CTRL:      ctrl_ff    <= bus_i.wdata;
        `LPC_OFS_LAM_NTP:   lam_ntp_ff <= bus_i.wdata;
        `LPC_OFS_LAM_CUR:   lam_cur_ff <= bus_i.wdata;
        `LPC_OFS_DEAD_PATH: dead_ff    <= bus_i.wdata;
        `LPC_OFS_ST_COEF:   st_coef_ff <= bus_i.wdata;
        `LPC_OFS_ST_TEMP:   st_temp_ff <= bus_i.wdata;
        `LPC_OFS_WP_COEF:   wp_coef_ff <= bus_i.wdata;
        `LPC_OFS_WP_TEMP:   wp_temp_ff <= bus_i.wdata;
        `LPC_OFS_WP_OFFSET: wp_off_ff  <= bus_i.wdata;
        default:            ctrl_ff    <= ctrl_ff;
      endcase
    end
  end

  // Read data stand for exactly the cycle after the strobe.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      rdata_o <= 32'h0000_0000;
    else
      rdata_o <= bus_i.rd ? rd_mux : 32'h0000_0000;
  end

  // Enable-time position, taken from the last finished axis value.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wpc_on_ff <= 1'b0;
      wce_ff    <= '0;
    end
    else
    begin
      wpc_on_ff <= wpc_en;
      if (wpc_rise)
        wce_ff <= axis_ff;
    end
  end

  // Sequencer: loops forever, so every input change shows by the end of the pass after the one it falls in.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_ff     <= lpc_pkg::ST_DIV;
      div_start_ff <= 1'b1;
      pos_in_ff    <= '0;
      wl_corr_ff   <= '0;
      dp_corr_ff   <= '0;
      st_corr_ff   <= '0;
      axis_ff      <= '0;
      wp1_ff       <= '0;
      wp_corr_ff   <= '0;
      out_o        <= '0;
    end
    else
    begin
      div_start_ff <= 1'b0;
      out_o.valid  <= 1'b0;
      unique case (state_ff)
        lpc_pkg::ST_DIV:
        begin
          pos_in_ff <= pos_in;
          if (r1_done && r2_done)
            state_ff <= lpc_pkg::ST_MUL;
        end
        lpc_pkg::ST_MUL:
        begin
          wl_corr_ff <= wl_full[`LPC_RATIO_FRAC +: POS_W];
          dp_corr_ff <= dp_full[`LPC_RATIO_FRAC +: POS_W];
          st_corr_ff <= st_full[32 +: POS_W];
          state_ff   <= lpc_pkg::ST_AXIS;
        end
        lpc_pkg::ST_AXIS:
        begin
          axis_ff  <= axis_sum;
          state_ff <= lpc_pkg::ST_WP1;
        end
        lpc_pkg::ST_WP1:
        begin
          wp1_ff   <= wp1[87:16];
          state_ff <= lpc_pkg::ST_WP2;
        end
        lpc_pkg::ST_WP2:
        begin
          wp_corr_ff <= wpc_on_ff ? wp2[56 +: POS_W] : '0;
          state_ff   <= lpc_pkg::ST_OUT;
        end
        lpc_pkg::ST_OUT:
        begin
          out_o.valid  <= 1'b1;
          out_o.axis   <= axis_ff;
          out_o.pos    <= out_sum;
          div_start_ff <= 1'b1;
          state_ff     <= lpc_pkg::ST_DIV;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  ref_clear_a: assert property (ref_evt |=> cnt_ff == 32'sh0)
    else $error("count not cleared by reference");
  lam_latch_a: assert property (ref_evt |=> lam_ref_ff == $past(lam_cur_ff))
    else $error("reference wavelength not latched");
  wce_latch_a: assert property (wpc_rise |=> wce_ff == $past(axis_ff))
    else $error("enable-time position not latched");
  res_derive_a: assert property (ctrl_ff[`LPC_CTRL_INTERP_HI:`LPC_CTRL_DPASS] == 5'h0 |-> res_q22 == lam_ntp_ff)
    else $error("resolution differs from wavelength");
  axis_sum_a: assert property (state_ff == lpc_pkg::ST_AXIS |=>
      axis_ff == $past(pos_in_ff) + $past(wl_corr_ff) + $past(dp_corr_ff) + $past(st_corr_ff))
    else $error("axis position is not the corrected sum");
  out_sum_a: assert property (out_o.valid |-> out_o.pos == out_o.axis + wp_corr_ff)
    else $error("output position is not axis plus workpiece");
  st_sign_a: assert property (state_ff == lpc_pkg::ST_MUL && $signed(st_coef_ff) > 0 && st_dt < 0
      |=> st_corr_ff <= 0)
    else $error("structure correction has wrong sign");
  wp_off_a: assert property (state_ff == lpc_pkg::ST_WP2 && !wpc_on_ff |=> wp_corr_ff == '0)
    else $error("workpiece correction while disabled");
  recompute_a: assert property (out_o.valid |-> ##[1:80] out_o.valid)
    else $error("output not refreshed in time");

endmodule

// ==== tb/lpc_servo_model.sv ====
// Purpose: Servo-controller stand-in that takes each compensated position.
// Assumes: One clock; out_o.valid is a one-cycle pulse.
// Notes:   It only listens, so it can never stall the block.
`timescale 1ns/1ps

module lpc_servo_model (
  // Clock and reset.
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // Position from the block.
  input  wire lpc_pkg::lpc_out_s pos_i,
  // What the servo last took.
  output logic signed [47:0]     axis_o,
  output logic signed [47:0]     pos_o,
  output int                     n_valid_o,
  output int                     max_gap_o
);
  int gap;

  // Take each pulse and time the gap, since a stale demand would hold a wrong position.
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      n_valid_o <= 0;
      gap       <= 0;
      max_gap_o <= 0;
    end
    else if (pos_i.valid)
    begin
      axis_o    <= pos_i.axis;
      pos_o     <= pos_i.pos;
      n_valid_o <= n_valid_o + 1;
      gap       <= 0;
      if (gap > max_gap_o) max_gap_o <= gap;
    end
    else
    begin
      gap <= gap + 1;
    end
  end
endmodule

// ==== tb/lpc_top_test.sv ====
// Purpose: Self-checking bench of the position compensator.
// Assumes: Positions in 1/256 nm, wavelengths nm Q22, temperatures Q16.
// Notes:   Powers of two keep the wavelength ratios exact.
`timescale 1ns/1ps
`include "lpc_defs.svh"

module lpc_top_test;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              qa = 1'b0;
  logic              qb = 1'b0;
  logic              ref_pin = 1'b0;
  lpc_pkg::lpc_bus_s bus = '0;
  logic [31:0]       rdata;
  lpc_pkg::lpc_out_s out;
  logic signed [47:0] sv_axis;
  logic signed [47:0] sv_pos;
  int                n_valid;
  int                max_gap;
  int                miscompares = 0;
  int                n_checks = 0;
  int                phase = 0;

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  lpc_top dut (.clk_i(clk), .rst_n_i(rst_n), .quad_a_i(qa), .quad_b_i(qb), .ref_i(ref_pin),
               .bus_i(bus), .rdata_o(rdata), .out_o(out));

  lpc_servo_model servo (.clk_i(clk), .rst_n_i(rst_n), .pos_i(out), .axis_o(sv_axis),
                         .pos_o(sv_pos), .n_valid_o(n_valid), .max_gap_o(max_gap));

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic signed [63:0] got, input logic signed [63:0] exp, input logic [63:0] tol);
    logic signed [63:0] d;
    d = got - exp;
    if (d < 0) d = -d;
    n_checks++;
    if ($isunknown(got) || d > tol)
    begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just after that edge.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    bus <= '0;
    #1;
    chk({32'h0, rdata}, {32'h0, exp}, 64'h0);
  endtask

  // Gray steps held three cycles each; a negative count walks backwards.
  task automatic step(input int n);
    repeat (n < 0 ? -n : n)
    begin
      phase = (phase + (n < 0 ? 3 : 1)) % 4;
      @(posedge clk);
      qa <= (phase >= 2);
      qb <= (phase == 1) || (phase == 2);
      repeat (2) @(posedge clk);
    end
  endtask

  task automatic reference();
    @(posedge clk);
    ref_pin <= 1'b1;
    repeat (4) @(posedge clk);
    ref_pin <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // Two pulses guarantee a whole pass that began after the last change.
  task automatic ck_out(input logic signed [63:0] ax, input logic signed [63:0] ps, input logic [63:0] tol);
    int n0;
    int k;
    n0 = n_valid;
    k = 0;
    while (n_valid < n0 + 2 && k < 300)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= 300)
      miscompares++;
    #1;
    chk(sv_axis, ax, tol);
    chk(sv_pos, ps, tol);
  endtask

  task automatic t_reset();
    repeat (5) @(posedge clk);
    #1;
    chk(out.axis, 64'h0, 64'h0);
    chk(out.pos, 64'h0, 64'h0);
    chk(64'(out.valid), 64'h0, 64'h0);
    chk({32'h0, rdata}, 64'h0, 64'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(`LPC_OFS_CTRL, `LPC_RST_CTRL);
    rd_chk(8'h40, 32'h0);
    wr(`LPC_OFS_COUNT, 32'h55);
    rd_chk(`LPC_OFS_COUNT, 32'h0);
  endtask

  task automatic t_count();
    wr(`LPC_OFS_LAM_NTP, 32'h2000_0000);
    wr(`LPC_OFS_LAM_CUR, 32'h2000_0000);
    wr(`LPC_OFS_CTRL, 32'h0000_0008);
    step(3);
    reference();
    rd_chk(`LPC_OFS_COUNT, 32'h0);
    rd_chk(`LPC_OFS_LAM_REF, 32'h2000_0000);
    rd_chk(`LPC_OFS_STATUS, 32'h0000_0001);
    step(6); // forward motion counts up
    step(-2);
    rd_chk(`LPC_OFS_COUNT, 32'h0000_0004);
    ck_out(32768, 32768, 0);
    rd_chk(`LPC_OFS_AXIS_LO, 32'h0000_8000);
    rd_chk(`LPC_OFS_AXIS_HI, 32'h0);
    wr(`LPC_OFS_CTRL, 32'h0000_000A);
    ck_out(16384, 16384, 0); // double pass halves resolution
    wr(`LPC_OFS_CTRL, 32'h0000_0008);
  endtask

  task automatic t_struct();
    wr(`LPC_OFS_ST_COEF, 32'h0001_0000);
    wr(`LPC_OFS_ST_TEMP, 32'h0015_0000);
    ck_out(32768 - 256000, 32768 - 256000, 2);
    wr(`LPC_OFS_ST_TEMP, 32'h0014_0000);
    ck_out(32768, 32768, 2);
  endtask

  task automatic t_lambda();
    wr(`LPC_OFS_DEAD_PATH, 32'h0000_0001); // positive dead path
    wr(`LPC_OFS_LAM_CUR, 32'h4000_0000);
    ck_out(321536, 321536, 2); // positive terms raise the position
    reference();
    rd_chk(`LPC_OFS_LAM_REF, 32'h4000_0000);
    ck_out(0, 0, 2); // no jump at referencing
    wr(`LPC_OFS_LAM_CUR, 32'h2000_0000);
    ck_out(-128000, -128000, 2);
    rd_chk(`LPC_OFS_AXIS_HI, 32'h0000_FFFF);
    wr(`LPC_OFS_CTRL, 32'h0000_000A);
    ck_out(-128000, -128000, 2); // double pass leaves the physical dead path alone
    wr(`LPC_OFS_CTRL, 32'h0000_0008);
    wr(`LPC_OFS_DEAD_PATH, 32'h0);
  endtask

  task automatic t_work();
    step(4);
    ck_out(32768, 32768, 0); // settle the axis before the enable point is taken
    wr(`LPC_OFS_WP_COEF, 32'h000A_0000);
    wr(`LPC_OFS_WP_TEMP, 32'h001E_0000);
    wr(`LPC_OFS_WP_OFFSET, 32'hFFFF_FC18); // offset of minus 1000 um
    wr(`LPC_OFS_CTRL, 32'h0000_0009);
    ck_out(32768, 32768 - 25600, 4);
    rd_chk(`LPC_OFS_STATUS, 32'h0000_0003);
    step(4);
    ck_out(65536, 65536 - 25603, 4); // enable point held
    wr(`LPC_OFS_CTRL, 32'h0000_0008);
    ck_out(65536, 65536, 0);
    rd_chk(`LPC_OFS_OUT_LO, 32'h0001_0000);
    rd_chk(`LPC_OFS_OUT_HI, 32'h0);
  endtask

  // Main sequence.
  initial
  begin
    t_reset();
    t_count();
    t_struct();
    t_lambda();
    t_work();
    chk(64'(max_gap <= 80), 64'h1, 64'h0);
    end_of_test();
  end

  // Watchdog well beyond the few thousand cycles the tests need.
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
endmodule
